// >>> include/sac_pkg.sv
// Package of constants and types for the SAR converter control block
// Contract
// R1 - Convert held sample to 12 bits by SAR
// R2 - Mux one of ten inputs into hold stage
// R3 - Software picks supply rails or external reference
// R4 - Keep converting in sleep on RC clock
// R5 - Six 16-bit control and select registers
// R6 - Pin config sets analog or digital pins
// R7 - Non-scan conversions use channel select register
// R8 - Scan only inputs set in scan register
// R9 - Software leaves key fields alone while on
// R10 - Software keeps sample rate at 200 ksps max
// R11 - Software keeps conversion clock period 334/668 ns
// R12 - Hold one clock, convert, store, flag done
package sac_pkg;
  localparam int RES_BITS = 12;
  localparam int NUM_INPUTS = 10;
  localparam int REG_W = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TAD_MIN_NS = 334;
  localparam int TAD_MIN_CYC = (TAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUF_DEPTH = 16;
  localparam logic [15:0] CTL1_RESET = 16'h0000;
  localparam logic [15:0] CTL2_RESET = 16'h0000;
  localparam logic [15:0] CTL3_RESET = 16'h0000;
  localparam logic [15:0] CHSEL_RESET = 16'h0000;
  localparam logic [15:0] PINCFG_RESET = 16'h0000;
  localparam logic [15:0] SCAN_RESET = 16'h0000;
  // Control 1 fields
  localparam int C1_ON = 15;
  localparam int C1_SIDL = 13;
  localparam int C1_TRIG_LO = 5;
  localparam int C1_AUTO_SAMPLE_ENABLE = 2;
  localparam int C1_SAMP = 1;
  localparam int C1_DONE = 0;
  // Control 2 fields
  localparam int C2_VREF_LO = 13;
  localparam int C2_CSCNA = 10;
  localparam int C2_SAMPLES_PER_INTERRUPT_LO = 2;
  localparam int C2_BUFFER_FILL_MODE = 1;
  localparam int C2_ALTERNATE_INPUT_SEL = 0;
  // Control 3 fields
  localparam int C3_SAMC_LO = 8;
  localparam int C3_ADRC = 7;
  localparam int C3_ADCS_LO = 0;
  // Channel select fields
  localparam int CH_A_LO = 0;
  localparam int CH_B_LO = 8;
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_SAMPLE = 2'b01,
    SAC_CONVERT = 2'b11,
    SAC_STORE = 2'b10
  } sac_state_e;
endpackage

// >>> rtl/sac_sar_core.sv
// Successive-approximation bit sequencer, one bit per conversion clock
`timescale 1ns/10ps
module sac_sar_core
  import sac_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic tad_tick,
  input wire logic comp_hi,
  output logic [WIDTH-1:0] dac_code,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] result
);
  logic [WIDTH-1:0] trial_bit;
  logic [WIDTH-1:0] acc;
  wire [WIDTH-1:0] kept = comp_hi ? dac_code : acc;
  assign dac_code = acc | trial_bit;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trial_bit <= '0;
      acc <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        trial_bit <= {1'b1, {(WIDTH-1){1'b0}}};
        acc <= '0;
        busy <= 1'b1;
      end else if (busy && tad_tick) begin
        // Keep trial bit when comparator says input is above the DAC [R1]
        acc <= kept;
        trial_bit <= trial_bit >> 1;
        if (trial_bit[0]) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= kept;
        end
      end
    end
  end
endmodule // sac_sar_core

// >>> rtl/sac_adc_ctrl.sv
// Top-level control of the 12-bit SAR converter
`timescale 1ns/10ps
module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int NUM_IN = NUM_INPUTS,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rc_clk_tick,
  input wire logic cpu_sleep,
  input wire logic [15:0] conv_control_1,
  input wire logic [15:0] conv_control_2,
  input wire logic [15:0] conv_control_3,
  input wire logic [15:0] input_channel_select,
  input wire logic [15:0] pin_analog_config,
  input wire logic [15:0] scan_input_select,
  input wire logic manual_sample_start,
  input wire logic ext_trigger,
  input wire logic comp_hi,
  input wire logic [3:0] buf_rd_index,
  output logic [3:0] mux_select,
  output logic sample_hold_en,
  output logic [1:0] ref_select,
  output logic [11:0] dac_code,
  output logic [NUM_IN-1:0] pin_is_digital,
  output logic [11:0] buf_rd_data,
  output logic conv_done,
  output logic conv_irq,
  output logic busy
);
  // Register inputs from software [R5]
  wire converter_on = conv_control_1[C1_ON];
  wire stop_in_idle = conv_control_1[C1_SIDL];
  wire [2:0] trigger_source_sel = conv_control_1[C1_TRIG_LO +: 3];
  wire auto_sample_enable = conv_control_1[C1_AUTO_SAMPLE_ENABLE];
  wire [3:0] samples_per_interrupt = conv_control_2[C2_SAMPLES_PER_INTERRUPT_LO +: 4];
  wire scan_enable = conv_control_2[C2_CSCNA];
  wire buffer_fill_mode = conv_control_2[C2_BUFFER_FILL_MODE];
  wire alternate_input_sel = conv_control_2[C2_ALTERNATE_INPUT_SEL];
  wire [4:0] sample_tads = conv_control_3[C3_SAMC_LO +: 5];
  wire rc_clock_sel = conv_control_3[C3_ADRC];
  wire [5:0] tad_div = conv_control_3[C3_ADCS_LO +: 6];

  // Sleep with stop-in-idle set stops the system clock path; the RC path keeps running [R4]
  wire clk_live = rc_clock_sel || !(cpu_sleep && stop_in_idle);
  wire run = converter_on && clk_live;

  // Conversion clock: RC ticks or a divided system clock never below the floor
  logic [7:0] tad_cnt;
  wire [7:0] tad_limit_raw = {1'b0, tad_div, 1'b1};
  wire [7:0] tad_limit = (tad_limit_raw < 8'(TAD_MIN_CYC - 1)) ? 8'(TAD_MIN_CYC - 1) : tad_limit_raw;
  wire sys_tick = (tad_cnt >= tad_limit);
  wire tad_tick = rc_clock_sel ? rc_clk_tick : sys_tick;
  // RC ticks are not realigned, so the first RC sampling Tad may run short

  // Reference: 0 = analog supply rails, others use external pins [R3]
  assign ref_select = conv_control_2[C2_VREF_LO +: 2];

  // Pins cleared to 0 are analog inputs, set to 1 are digital [R6]
  assign pin_is_digital = pin_analog_config[NUM_IN-1:0];

  function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [15:0] mask);
    logic [3:0] pick;
    logic [3:0] idx;
    pick = cur;
    for (int k = 1; k <= NUM_INPUTS; k++) begin
      idx = 4'((int'(cur) + k) % NUM_INPUTS);
      if (mask[idx] && pick == cur) begin
        pick = idx;
      end
    end
    return pick;
  endfunction

  sac_state_e state;
  sac_state_e next_state;
  logic [4:0] samp_cnt;
  logic [3:0] scan_ch;
  logic scan_fresh;
  logic alt_phase;
  logic [3:0] fill_ptr;
  logic buf_half;
  logic [3:0] seq_cnt;
  logic [11:0] result_buf [DEPTH];
  logic sar_start;
  logic sar_busy;
  logic sar_done;
  logic [11:0] sar_result;

  // Channel is scan pick or the select register's A/B field [R7] [R8]
  wire [3:0] fixed_ch = alternate_input_sel && alt_phase ? input_channel_select[CH_B_LO +: 4]
                                                         : input_channel_select[CH_A_LO +: 4];
  // A fresh scan restarts from the lowest enabled input, even right after reset [R8]
  wire [3:0] scan_first = next_scan(4'(NUM_INPUTS - 1), scan_input_select);
  wire [3:0] scan_pick = scan_fresh ? scan_first : scan_ch;
  wire [3:0] chan = scan_enable ? scan_pick : fixed_ch;
  wire [3:0] chan_ok = (chan < 4'(NUM_IN)) ? chan : 4'h0;

  wire trigger_now = (trigger_source_sel == TRIG_AUTO) ? 1'b1
                   : (trigger_source_sel == TRIG_MANUAL) ? manual_sample_start : ext_trigger;
  wire samp_met = (samp_cnt >= sample_tads) && (samp_cnt != 5'h00);
  wire begin_sample = auto_sample_enable || conv_control_1[C1_SAMP];
  wire irq_point = (seq_cnt == samples_per_interrupt);

  always_comb begin
    next_state = state;
    case (state)
      SAC_IDLE: if (run && begin_sample) next_state = SAC_SAMPLE;
      // At least one conversion clock of sampling before converting [R12]
      SAC_SAMPLE: if (!run) next_state = SAC_IDLE;
        else if (samp_met && trigger_now) next_state = SAC_CONVERT;
      SAC_CONVERT: if (sar_done) next_state = SAC_STORE;
      SAC_STORE: next_state = SAC_IDLE;
      default: next_state = SAC_IDLE;
    endcase
  end

  assign sar_start = (state == SAC_SAMPLE) && (next_state == SAC_CONVERT);
  assign sample_hold_en = (state == SAC_SAMPLE); // [R2]
  assign busy = sar_busy || (state != SAC_IDLE);

  sac_sar_core #(.WIDTH(RES_BITS)) u_sar (
    .core_clk(core_clk),
    .rst(rst),
    .start(sar_start),
    .tad_tick(tad_tick),
    .comp_hi(comp_hi),
    .dac_code(dac_code),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tad_cnt <= 8'h00;
    end else begin
      // Restart while idle so the first sampling Tad is a full period [R12]
      tad_cnt <= (sys_tick || !run || state == SAC_IDLE) ? 8'h00 : tad_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= SAC_IDLE;
      samp_cnt <= 5'h00;
      mux_select <= 4'h0;
    end else begin
      state <= next_state;
      if (state != SAC_SAMPLE) begin
        samp_cnt <= 5'h00;
      end else if (tad_tick && samp_cnt != 5'h1f) begin
        samp_cnt <= samp_cnt + 5'h01;
      end
      if (state == SAC_IDLE) begin
        mux_select <= chan_ok; // [R2]
      end
    end
  end

  // Result storage; a result that lands after switch-off is dropped [R12]
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        result_buf[i] <= 12'h000;
      end
    end else if (converter_on && sar_done) begin
      result_buf[fill_ptr] <= sar_result; // [R1]
    end
  end

  // Sequence count, scan position and done flag [R12]
  // Split buffer halves let software read one half while the other fills
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scan_ch <= 4'h0;
      scan_fresh <= 1'b1;
      alt_phase <= 1'b0;
      fill_ptr <= 4'h0;
      buf_half <= 1'b0;
      seq_cnt <= 4'h0;
      conv_done <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= 1'b0;
      if (!converter_on) begin
        fill_ptr <= 4'h0;
        seq_cnt <= 4'h0;
        buf_half <= 1'b0;
        alt_phase <= 1'b0;
        scan_fresh <= 1'b1; // [R8]
      end else if (sar_done) begin
        conv_done <= 1'b1;
        alt_phase <= !alt_phase;
        // Step on from the input just converted [R8]
        scan_ch <= next_scan(mux_select, scan_input_select);
        scan_fresh <= 1'b0;
        if (irq_point) begin
          conv_irq <= 1'b1;
          seq_cnt <= 4'h0;
          buf_half <= buffer_fill_mode ? !buf_half : 1'b0;
          fill_ptr <= buffer_fill_mode ? (buf_half ? 4'h0 : 4'h8) : 4'h0;
          scan_fresh <= 1'b1;
          alt_phase <= 1'b0;
        end else begin
          seq_cnt <= seq_cnt + 4'h1;
          fill_ptr <= fill_ptr + 4'h1;
        end
      end else if (begin_sample && state == SAC_IDLE && run) begin
        conv_done <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_rd_data <= 12'h000;
    end else begin
      buf_rd_data <= result_buf[buf_rd_index];
    end
  end
endmodule // sac_adc_ctrl

// >>> dv/sac_adc_ctrl_asserts.sv
// Checker for the SAR converter control block
`timescale 1ns/10ps
module sac_adc_ctrl_asserts
  import sac_pkg::*;
#(
  parameter int NUM_IN = NUM_INPUTS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] conv_control_1,
  input wire logic [15:0] conv_control_2,
  input wire logic [15:0] conv_control_3,
  input wire logic [15:0] input_channel_select,
  input wire logic [15:0] pin_analog_config,
  input wire logic [15:0] scan_input_select,
  input wire logic [3:0] mux_select,
  input wire logic sample_hold_en,
  input wire logic [1:0] ref_select,
  input wire logic [NUM_IN-1:0] pin_is_digital,
  input wire logic conv_done,
  input wire logic conv_irq
);
  wire [15:0] c1 = conv_control_1;
  wire [15:0] c2 = conv_control_2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ref_follow: assert property (ref_select == c2[14:13])
    else $error("Reference select wrong");
  a_pin_config: assert property (pin_is_digital == pin_analog_config[NUM_IN-1:0])
    else $error("Pin mode wrong");
  a_mux_range: assert property (mux_select < NUM_IN)
    else $error("Channel out of range");
  a_fixed_chan: assert property (sample_hold_en && $past(sample_hold_en) && !c2[10] && !c2[0]
    |-> mux_select == input_channel_select[3:0]) else $error("Fixed channel wrong");
  a_scan_member: assert property (sample_hold_en && $past(sample_hold_en) && c2[10]
    |-> scan_input_select[mux_select]) else $error("Scan channel not enabled");
  a_hold_off: assert property (!c1[15] && !$past(c1[15]) |-> !sample_hold_en)
    else $error("Sampling while off");
  a_irq_pulse: assert property (conv_irq |=> !conv_irq)
    else $error("Completion pulse too long");
  a_conv_len: assert property ($rose(conv_done) && !conv_control_3[7] |-> !$past(sample_hold_en, 8))
    else $error("Conversion too short");
  c_done: cover property ($rose(conv_done));
  c_scan: cover property (sample_hold_en && c2[10]);
  c_irq: cover property (conv_irq);
  c_ext_wait: cover property (sample_hold_en && c1[7:5] == 3'h1);
endmodule // sac_adc_ctrl_asserts
bind sac_adc_ctrl sac_adc_ctrl_asserts #(.NUM_IN(NUM_IN)) u_chk (.core_clk, .rst, .conv_control_1,
  .conv_control_2, .conv_control_3, .input_channel_select, .pin_analog_config, .scan_input_select,
  .mux_select, .sample_hold_en, .ref_select, .pin_is_digital, .conv_done, .conv_irq);

// >>> dv/sac_analog_model.sv
// Analog pins, sample-and-hold and comparator seen by the control block
`timescale 1ns/10ps
module sac_analog_model
  import sac_pkg::*;
(
  input wire logic core_clk,
  input wire logic [3:0] mux_select,
  input wire logic sample_hold_en,
  input wire logic [11:0] dac_code,
  output logic comp_hi
);
  logic [11:0] held = 12'h000;
  // Tracks the selected pin while sampling, frozen once the hold opens
  always @(posedge core_clk) begin
    if (sample_hold_en) begin
      held <= 12'h0a3 + 12'(mux_select) * 12'h155;
    end
  end
  assign comp_hi = held >= dac_code;
endmodule // sac_analog_model

// >>> dv/test_sac_adc_ctrl.sv
// Self-checking bench for the SAR converter control block
`timescale 1ns/10ps
module test_sac_adc_ctrl;
  import sac_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, rc_clk_tick = 1'b0, cpu_sleep = 1'b0, comp_hi;
  logic [15:0] ctl1 = 16'h0000, ctl2 = 16'h0000, ctl3 = 16'h0000;
  logic [15:0] chsel = 16'h0000, pcfg = 16'h0000, scan = 16'h0000;
  logic [3:0] rd_idx = 4'h0, mux_select;
  logic man_start = 1'b0, ext_trig = 1'b0;
  logic sample_hold_en, conv_done, conv_irq, busy;
  logic [1:0] ref_select;
  logic [11:0] dac_code, buf_rd_data;
  logic [NUM_INPUTS-1:0] pin_is_digital;
  int n_fail = 0, n_tests = 0, tick_cnt = 0;
  always #4 core_clk = ~core_clk;
  // RC conversion clock of 672 ns keeps the slower Tad floor with supply rails
  always @(posedge core_clk) begin
    tick_cnt <= (tick_cnt == 83) ? 0 : tick_cnt + 1;
    rc_clk_tick <= #1 (tick_cnt == 83);
  end
  sac_adc_ctrl i_dut (.core_clk(core_clk), .rst(rst), .rc_clk_tick(rc_clk_tick), .cpu_sleep(cpu_sleep),
    .conv_control_1(ctl1), .conv_control_2(ctl2), .conv_control_3(ctl3), .input_channel_select(chsel),
    .pin_analog_config(pcfg), .scan_input_select(scan), .manual_sample_start(man_start), .ext_trigger(ext_trig),
    .comp_hi(comp_hi), .buf_rd_index(rd_idx), .mux_select(mux_select), .sample_hold_en(sample_hold_en),
    .ref_select(ref_select), .dac_code(dac_code), .pin_is_digital(pin_is_digital),
    .buf_rd_data(buf_rd_data), .conv_done(conv_done), .conv_irq(conv_irq), .busy(busy));
  sac_analog_model i_pins (.core_clk(core_clk), .mux_select(mux_select), .sample_hold_en(sample_hold_en),
    .dac_code(dac_code), .comp_hi(comp_hi));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Settings change only with the converter off, and a reset follows each change except the manual-trigger chsel one
  task automatic reset_dut();
    rst = 1'b1;
    tick(8);
    rst = 1'b0;
  endtask
  task automatic wait_done();
    int i;
    i = 0;
    while (conv_done !== 1'b0 && i < 3000) begin
      tick(1);
      i++;
    end
    while (conv_done !== 1'b1 && i < 3000) begin
      tick(1);
      i++;
    end
    check("done wait", {15'h0, conv_done}, 16'h0001);
  endtask
  // Buffer data is registered, so allow it to settle after the index moves
  task automatic rd(logic [3:0] idx, int ch);
    rd_idx = idx;
    tick(3);
    check("buffer", {4'h0, buf_rd_data}, {4'h0, 12'h0a3 + 12'(ch) * 12'h155});
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  initial begin
    // Sample 3 Tad plus 12 Tad keeps the rate under 200 ksps
    ctl2 = 16'h2000;
    ctl3 = 16'h0301;
    chsel = 16'h0503;
    pcfg = 16'h0205;
    reset_dut();
    ctl1 = 16'h80e4;
    wait_done();
    check("irq", {15'h0, conv_irq}, 16'h0001);
    check("ref", {14'h0, ref_select}, 16'h0001);
    check("pins", {6'h0, pin_is_digital}, 16'h0205);
    ctl1 = 16'h0000;
    rd(4'h0, 3);
    check("busy", {15'h0, busy}, 16'h0000);
    $display("Test fixed channel done");
    ctl2 = 16'h0404;
    ctl3 = 16'h0380;
    scan = 16'h0084;
    cpu_sleep = 1'b1;
    reset_dut();
    ctl1 = 16'ha0e4;
    wait_done();
    check("irq", {15'h0, conv_irq}, 16'h0000);
    wait_done();
    check("irq", {15'h0, conv_irq}, 16'h0001);
    ctl1 = 16'h0000;
    check("ref", {14'h0, ref_select}, 16'h0000);
    rd(4'h0, 2);
    rd(4'h1, 7);
    $display("Test scan in sleep done");
    // External trigger, alternate A/B inputs and split buffer halves
    ctl2 = 16'h2007;
    ctl3 = 16'h0301;
    chsel = 16'h0504;
    cpu_sleep = 1'b0;
    reset_dut();
    ctl1 = 16'h8024;
    tick(300);
    check("hold wait", {15'h0, sample_hold_en}, 16'h0001);
    check("no trigger", {15'h0, conv_done}, 16'h0000);
    check("busy", {15'h0, busy}, 16'h0001);
    ext_trig = 1'b1;
    wait_done();
    check("irq", {15'h0, conv_irq}, 16'h0000);
    wait_done();
    check("irq", {15'h0, conv_irq}, 16'h0001);
    wait_done();
    ctl1 = 16'h0000;
    ext_trig = 1'b0;
    rd(4'h0, 4);
    rd(4'h1, 5);
    rd(4'h8, 4);
    // Manual trigger with the sample bit set by software
    chsel = 16'h0506;
    man_start = 1'b1;
    ctl1 = 16'h8002;
    wait_done();
    check("irq", {15'h0, conv_irq}, 16'h0000);
    ctl1 = 16'h0000;
    man_start = 1'b0;
    rd(4'h0, 6);
    $display("Test triggers and split buffer done");
    complete_run();
  end
endmodule // test_sac_adc_ctrl
